// ==== pkg/exec_cfg.svh ====
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// ****************************************
// Direct addresses of the held registers
// ****************************************
`define DADR_ACC   8'he0
`define DADR_B     8'hf0
`define DADR_PSW   8'hd0
`define DADR_DPL   8'h82
`define DADR_DPH   8'h83

// ****************************************
// Status word fields
// ****************************************
`define PSW_CY     7
`define PSW_AC     6
`define PSW_RS_HI  4
`define PSW_RS_LO  3
`define PSW_OV     2
`define PSW_P      0

// ****************************************
// Reset values
// ****************************************
`define ACC_RST    8'h00
`define B_RST      8'h00
`define PSW_RST    8'h00
`define DP_RST     16'h0000

// ****************************************
// Cycle counts per instruction form
// ****************************************
`define CYC_REG    3'h1
`define CYC_MEM    3'h2
`define CYC_INCREG 3'h2
`define CYC_RMW    3'h3
`define CYC_PROD   3'h2
`define CYC_DA     3'h3
`define CYC_DIV    3'h6
`define CYC_MOVC   3'h5
`define CYC_XRD_RI 3'h4
`define CYC_XRD_DP 3'h3
`define CYC_XWR_RI 3'h5
`define CYC_XWR_DP 3'h4

`endif

// ==== pkg/exec_pkg.sv ====
package exec_pkg;

	typedef enum logic [4:0] {
		OP_NONE, OP_ADD, OP_ADDCY, OP_SUBCY, OP_AND, OP_OR, OP_XOR, OP_INC, OP_DEC,
		OP_INCDP, OP_PROD, OP_DIV, OP_DA, OP_CLR, OP_INV, OP_RL, OP_RLCY, OP_RR, OP_RRCY,
		OP_SWAP, OP_MOV, OP_STA, OP_MOVC, OP_XRD, OP_XWR
	} op_e;

	typedef enum logic [2:0] {SRC_ACC, SRC_IMM, SRC_DIR, SRC_IND, SRC_REG} src_e;

	typedef enum logic [1:0] {DST_ACC, DST_SRC, DST_DIR2} dst_e;

	typedef struct packed {
		op_e        op;
		src_e       src;
		dst_e       dst;
		logic       imm2;
		logic [2:0] cyc;
	} decode_s;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] byte1;
		logic [7:0] byte2;
	} instr_s;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        code;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} memreq_s;

	typedef struct packed {
		logic [7:0]  acc;
		logic [7:0]  b;
		logic [7:0]  psw;
		logic [15:0] dataPtr;
	} archstate_s;

endpackage

// ==== core/exec_iram.sv ====
`timescale 1ns/10ps
module exec_iram #(
	parameter int AW = 8
) (
	input  wire logic          sys_clk,
	input  wire logic [AW-1:0] rdAddrA,
	output logic      [7:0]    rdDataA,
	input  wire logic [AW-1:0] rdAddrB,
	output logic      [7:0]    rdDataB,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [7:0]    wrData
);
	// Pointer-indirect addresses reach the full byte range
	generate
		if (AW != 8) begin : g_chk
			$error("exec_iram needs AW of 8");
		end
	endgenerate

	logic [7:0] mem [2**AW];

	assign rdDataA = mem[rdAddrA];
	assign rdDataB = mem[rdAddrB];

	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end
endmodule

// ==== core/cpu_arith_logic_exec.sv ====
`timescale 1ns/10ps
`include "exec_cfg.svh"
// Overview of operation
// - Add bank register: one byte, one cycle
// - Add direct, indirect, immediate: two cycles
// - Add with carry: register one, others two
// - Subtract with borrow: register one, others two
// - Inc/dec timing; data pointer increment one cycle
// - Multiply two cycles; decimal fixup three cycles
// - Divide by aux operand in six cycles
// - Logic operations act bit by bit
// - AND into accumulator: register one, others two
// - AND into direct byte: three cycles
// - OR into accumulator: register one, others two
// - OR into direct byte: three cycles
// - XOR into accumulator: register one, others two
// - XOR into direct byte: three cycles
// - Clear, invert, rotates: one cycle each
// - Nibble swap of accumulator in one cycle
// - Internal moves use direct, indirect, register, immediate
// - External data only via accumulator, indirect addressing
// - Table lookups only read program memory
// - Lookup address is data pointer plus accumulator
// - Indirect: 8-bit from pointer, 16-bit from data pointer
module cpu_arith_logic_exec
	import exec_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire instr_s     instr,
	input  wire logic       instrValid,
	output logic            instrReady,
	output logic            retired,
	output logic            badOpcode,
	output memreq_s         memReq,
	input  wire logic [7:0] memRdData,
	output archstate_s      archState
);
	// ****************************************
	// Decode
	// ****************************************
	function automatic decode_s decode(input logic [7:0] opc);
		decode_s    d;
		src_e       m;
		logic [2:0] mc;
		m  = opc[3] ? SRC_REG : (opc[3:1] == 3'h3) ? SRC_IND : (opc[3:0] == 4'h5) ? SRC_DIR : SRC_IMM;
		mc = (m == SRC_REG) ? `CYC_REG : `CYC_MEM;
		d  = '{OP_NONE, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
		if (opc[3:2] != 2'h0) begin
			case (opc[7:4])
				4'h2: d = '{OP_ADD, m, DST_ACC, 1'b0, mc};
				4'h3: d = '{OP_ADDCY, m, DST_ACC, 1'b0, mc};
				4'h9: d = '{OP_SUBCY, m, DST_ACC, 1'b0, mc};
				4'h5: d = '{OP_AND, m, DST_ACC, 1'b0, mc};
				4'h4: d = '{OP_OR, m, DST_ACC, 1'b0, mc};
				4'h6: d = '{OP_XOR, m, DST_ACC, 1'b0, mc};
				4'h0, 4'h1: d = '{opc[4] ? OP_DEC : OP_INC, m, DST_SRC, 1'b0,
					(m == SRC_REG) ? `CYC_INCREG : `CYC_RMW};
				4'he: if (opc[3:0] != 4'h4) d = '{OP_MOV, m, DST_ACC, 1'b0, mc};
				4'hf: if (opc[3:0] != 4'h4) d = '{OP_STA, m, DST_SRC, 1'b0, mc};
				default: ;
			endcase
		end
		case (opc)
			8'h04: d = '{OP_INC, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'h14: d = '{OP_DEC, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'ha3: d = '{OP_INCDP, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'h52: d = '{OP_AND, SRC_DIR, DST_SRC, 1'b0, `CYC_RMW};
			8'h53: d = '{OP_AND, SRC_DIR, DST_SRC, 1'b1, `CYC_RMW};
			8'h42: d = '{OP_OR, SRC_DIR, DST_SRC, 1'b0, `CYC_RMW};
			8'h43: d = '{OP_OR, SRC_DIR, DST_SRC, 1'b1, `CYC_RMW};
			8'h62: d = '{OP_XOR, SRC_DIR, DST_SRC, 1'b0, `CYC_RMW};
			8'h63: d = '{OP_XOR, SRC_DIR, DST_SRC, 1'b1, `CYC_RMW};
			8'h74: d = '{OP_MOV, SRC_IMM, DST_ACC, 1'b0, `CYC_MEM};
			8'h85: d = '{OP_MOV, SRC_DIR, DST_DIR2, 1'b0, `CYC_RMW};
			8'ha4: d = '{OP_PROD, SRC_ACC, DST_ACC, 1'b0, `CYC_PROD};
			8'hd4: d = '{OP_DA, SRC_ACC, DST_ACC, 1'b0, `CYC_DA};
			8'h84: d = '{OP_DIV, SRC_ACC, DST_ACC, 1'b0, `CYC_DIV};
			8'he4: d = '{OP_CLR, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'hf4: d = '{OP_INV, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'h23: d = '{OP_RL, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'h33: d = '{OP_RLCY, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'h03: d = '{OP_RR, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'h13: d = '{OP_RRCY, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'hc4: d = '{OP_SWAP, SRC_ACC, DST_ACC, 1'b0, `CYC_REG};
			8'h93: d = '{OP_MOVC, SRC_ACC, DST_ACC, 1'b0, `CYC_MOVC};
			8'he0: d = '{OP_XRD, SRC_ACC, DST_ACC, 1'b0, `CYC_XRD_DP};
			8'he2, 8'he3: d = '{OP_XRD, SRC_IND, DST_ACC, 1'b0, `CYC_XRD_RI};
			8'hf0: d = '{OP_XWR, SRC_ACC, DST_ACC, 1'b0, `CYC_XWR_DP};
			8'hf2, 8'hf3: d = '{OP_XWR, SRC_IND, DST_ACC, 1'b0, `CYC_XWR_RI};
			default: ;
		endcase
		return d;
	endfunction

	instr_s     instr_q;
	instr_s     cur;
	logic [2:0] cnt_q;
	decode_s    dec;
	decode_s    decIn;
	logic       take;
	logic       commit;
	logic [7:0] ptrAddr;
	logic [7:0] ptrData;
	logic [7:0] srcAddr;
	logic [7:0] dstAddr;
	logic [7:0] srcVal;
	logic [7:0] other;
	logic [7:0] ramData;
	logic [7:0] acc;
	logic [7:0] b;
	logic       cy;

	assign take   = instrValid && instrReady;
	assign commit = !instrReady && (cnt_q == 3'h1);
	// Pointer read must follow the incoming word so the request can be launched at accept
	assign cur    = instrReady ? instr : instr_q;
	assign dec    = decode(instr_q.opcode);
	assign decIn  = decode(instr.opcode);
	assign acc    = archState.acc;
	assign b      = archState.b;
	assign cy     = archState.psw[`PSW_CY];

	// ****************************************
	// Operand fetch
	// ****************************************
	assign ptrAddr = {3'h0, archState.psw[`PSW_RS_HI:`PSW_RS_LO], 2'h0, cur.opcode[0]};

	always_comb begin
		unique case (dec.src)
			SRC_REG: srcAddr = {3'h0, archState.psw[`PSW_RS_HI:`PSW_RS_LO], instr_q.opcode[2:0]};
			SRC_IND: srcAddr = ptrData;
			default: srcAddr = instr_q.byte1;
		endcase
		dstAddr = (dec.dst == DST_DIR2) ? instr_q.byte2 : srcAddr;
		other   = dec.imm2 ? instr_q.byte2 : acc;
		srcVal  = ramData;
		if (dec.src == SRC_IMM) begin
			srcVal = instr_q.byte1;
		end else if (dec.src == SRC_ACC) begin
			srcVal = acc;
		end else if (dec.src == SRC_DIR && srcAddr[7]) begin
			case (srcAddr)
				`DADR_ACC: srcVal = acc;
				`DADR_B:   srcVal = b;
				`DADR_PSW: srcVal = archState.psw;
				`DADR_DPL: srcVal = archState.dataPtr[7:0];
				`DADR_DPH: srcVal = archState.dataPtr[15:8];
				default:  ;
			endcase
		end
	end

	// ****************************************
	// Execute
	// ****************************************
	logic        cin;
	logic [8:0]  sum9;
	logic [7:0]  sum7;
	logic [4:0]  sum4;
	logic [8:0]  dif9;
	logic [7:0]  dif7;
	logic [4:0]  dif4;
	logic [15:0] prod;
	logic [8:0]  da1;
	logic [8:0]  da2;
	logic [7:0]  res;
	logic        useRes;
	logic        wr;
	logic        dstSfr;
	logic        ramWe;
	archstate_s  nxt;

	assign cin  = (dec.op == OP_ADDCY || dec.op == OP_SUBCY) ? cy : 1'b0;
	assign sum9 = {1'b0, srcVal} + {1'b0, other} + {8'h00, cin};
	assign sum7 = {1'b0, srcVal[6:0]} + {1'b0, other[6:0]} + {7'h00, cin};
	assign sum4 = {1'b0, srcVal[3:0]} + {1'b0, other[3:0]} + {4'h0, cin};
	assign dif9 = {1'b0, acc} - {1'b0, srcVal} - {8'h00, cin};
	assign dif7 = {1'b0, acc[6:0]} - {1'b0, srcVal[6:0]} - {7'h00, cin};
	assign dif4 = {1'b0, acc[3:0]} - {1'b0, srcVal[3:0]} - {4'h0, cin};
	assign prod = {8'h00, acc} * {8'h00, b};
	assign da1  = {1'b0, acc} + ((acc[3:0] > 4'h9 || archState.psw[`PSW_AC]) ? 9'h006 : 9'h000);
	assign da2  = da1 + ((da1[7:4] > 4'h9 || da1[8] || cy) ? 9'h060 : 9'h000);

	always_comb begin
		nxt    = archState;
		res    = srcVal;
		useRes = 1'b0;
		wr     = 1'b0;
		unique case (dec.op)
			OP_ADD, OP_ADDCY: begin
				nxt.acc              = sum9[7:0];
				nxt.psw[`PSW_CY]     = sum9[8];
				nxt.psw[`PSW_AC]     = sum4[4];
				nxt.psw[`PSW_OV]     = sum7[7] ^ sum9[8];
			end
			OP_SUBCY: begin
				nxt.acc              = dif9[7:0];
				nxt.psw[`PSW_CY]     = dif9[8];
				nxt.psw[`PSW_AC]     = dif4[4];
				nxt.psw[`PSW_OV]     = dif7[7] ^ dif9[8];
			end
			OP_AND: begin res = srcVal & other; useRes = 1'b1; end
			OP_OR:  begin res = srcVal | other; useRes = 1'b1; end
			OP_XOR: begin res = srcVal ^ other; useRes = 1'b1; end
			OP_INC: begin res = srcVal + 8'h01; useRes = 1'b1; end
			OP_DEC: begin res = srcVal - 8'h01; useRes = 1'b1; end
			OP_MOV: useRes = 1'b1;
			OP_STA: begin res = acc; useRes = 1'b1; end
			OP_INCDP: nxt.dataPtr = archState.dataPtr + 16'h0001;
			OP_PROD: begin
				nxt.acc          = prod[7:0];
				nxt.b            = prod[15:8];
				nxt.psw[`PSW_CY] = 1'b0;
				nxt.psw[`PSW_OV] = |prod[15:8];
			end
			OP_DIV: begin
				nxt.psw[`PSW_CY] = 1'b0;
				nxt.psw[`PSW_OV] = (b == 8'h00);
				// Zero divisor leaves both operands untouched
				if (b != 8'h00) begin
					nxt.acc = acc / b;
					nxt.b   = acc % b;
				end
			end
			OP_DA: begin
				nxt.acc          = da2[7:0];
				nxt.psw[`PSW_CY] = cy | da1[8] | da2[8];
			end
			OP_CLR:  nxt.acc = 8'h00;
			OP_INV:  nxt.acc = ~acc;
			OP_RL:   nxt.acc = {acc[6:0], acc[7]};
			OP_RR:   nxt.acc = {acc[0], acc[7:1]};
			OP_RLCY: begin nxt.acc = {acc[6:0], cy}; nxt.psw[`PSW_CY] = acc[7]; end
			OP_RRCY: begin nxt.acc = {cy, acc[7:1]}; nxt.psw[`PSW_CY] = acc[0]; end
			OP_SWAP: nxt.acc = {acc[3:0], acc[7:4]};
			OP_MOVC, OP_XRD: nxt.acc = memRdData;
			default: ;
		endcase
		if (useRes) begin
			if (dec.dst == DST_ACC) begin
				nxt.acc = res;
			end else begin
				wr = 1'b1;
			end
		end
		dstSfr = wr && dstAddr[7] && (dec.src == SRC_DIR || dec.dst == DST_DIR2);
		if (dstSfr) begin
			case (dstAddr)
				`DADR_ACC: nxt.acc = res;
				`DADR_B:   nxt.b = res;
				`DADR_PSW: nxt.psw = res;
				`DADR_DPL: nxt.dataPtr[7:0] = res;
				`DADR_DPH: nxt.dataPtr[15:8] = res;
				default:  ;
			endcase
		end
		ramWe = commit && wr && !dstSfr;
		// Parity always tracks the new accumulator
		nxt.psw[`PSW_P] = ^nxt.acc;
	end

	exec_iram #(
		.AW(8)
	) u_iram (
		.sys_clk (sys_clk),
		.rdAddrA (ptrAddr),
		.rdDataA (ptrData),
		.rdAddrB (srcAddr),
		.rdDataB (ramData),
		.wrEn    (ramWe),
		.wrAddr  (dstAddr),
		.wrData  (res)
	);

	// ****************************************
	// Sequencing
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			instrReady <= 1'b1;
			cnt_q      <= 3'h0;
			instr_q    <= '0;
		end else if (take) begin
			instrReady <= 1'b0;
			cnt_q      <= decIn.cyc;
			instr_q    <= instr;
		end else if (commit) begin
			instrReady <= 1'b1;
		end else if (!instrReady) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			retired   <= 1'b0;
			badOpcode <= 1'b0;
		end else begin
			retired   <= commit;
			badOpcode <= commit && (dec.op == OP_NONE);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			archState <= '{`ACC_RST, `B_RST, `PSW_RST, `DP_RST};
		end else if (commit) begin
			archState <= nxt;
		end
	end

	// ****************************************
	// External data and program memory
	// ****************************************
	// Held for the whole instruction so slow memories see a stable request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			memReq <= '0;
		end else if (take && (decIn.op == OP_MOVC || decIn.op == OP_XRD || decIn.op == OP_XWR)) begin
			memReq.rd    <= (decIn.op != OP_XWR);
			memReq.wr    <= (decIn.op == OP_XWR);
			memReq.code  <= (decIn.op == OP_MOVC);
			memReq.wdata <= acc;
			if (decIn.op == OP_MOVC) begin
				memReq.addr <= archState.dataPtr + {8'h00, acc};
			end else if (decIn.src == SRC_IND) begin
				memReq.addr <= {8'h00, ptrData};
			end else begin
				memReq.addr <= archState.dataPtr;
			end
		end else if (commit) begin
			memReq <= '0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_busy1; !instrReady ##1 instrReady; endsequence
	sequence s_busy2; !instrReady [*2] ##1 instrReady; endsequence
	sequence s_busy3; !instrReady [*3] ##1 instrReady; endsequence
	sequence s_busy6; !instrReady [*6] ##1 instrReady; endsequence

	property p_add_reg; take && instr.opcode[7:3] == 5'h05 |=> s_busy1; endproperty
	a_add_reg: assert property (p_add_reg) else $error("add register not one cycle");
	property p_add_mem; take && instr.opcode inside {8'h24, 8'h25, 8'h26, 8'h27} |=> s_busy2; endproperty
	a_add_mem: assert property (p_add_mem) else $error("add memory not two cycles");
	property p_addcy_reg; take && instr.opcode[7:3] == 5'h07 |=> s_busy1 ##0 retired; endproperty
	a_addcy_reg: assert property (p_addcy_reg) else $error("add with carry timing wrong");
	property p_subcy_mem; take && instr.opcode inside {8'h94, 8'h95, 8'h96, 8'h97} |=> s_busy2; endproperty
	a_subcy_mem: assert property (p_subcy_mem) else $error("subtract memory not two cycles");
	property p_inc_dp;
		take && instr.opcode == 8'ha3 |-> ##2 archState.dataPtr == $past(archState.dataPtr, 2) + 16'h0001;
	endproperty
	a_inc_dp: assert property (p_inc_dp) else $error("data pointer increment wrong");
	property p_prod;
		take && instr.opcode == 8'ha4 |=> s_busy2 ##0
			({archState.b, archState.acc} == $past(archState.acc, 3) * $past(archState.b, 3));
	endproperty
	a_prod: assert property (p_prod) else $error("multiply result or timing wrong");
	property p_div; take && instr.opcode == 8'h84 |=> s_busy6; endproperty
	a_div: assert property (p_div) else $error("divide not six cycles");
	property p_and_imm;
		take && instr.opcode == 8'h54 |-> ##3 archState.acc == ($past(archState.acc, 3) & $past(instr.byte1, 3));
	endproperty
	a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");
	property p_or_dir; take && instr.opcode == 8'h43 |=> s_busy3; endproperty
	a_or_dir: assert property (p_or_dir) else $error("or to direct not three cycles");
	property p_xor_dir; take && instr.opcode == 8'h62 |=> s_busy3; endproperty
	a_xor_dir: assert property (p_xor_dir) else $error("xor to direct not three cycles");
	property p_swap;
		take && instr.opcode == 8'hc4 |-> ##2 archState.acc == {$past(archState.acc[3:0], 2), $past(archState.acc[7:4], 2)};
	endproperty
	a_swap: assert property (p_swap) else $error("nibble swap wrong");
	property p_xwr; memReq.wr |-> !memReq.code && memReq.wdata == archState.acc; endproperty
	a_xwr: assert property (p_xwr) else $error("external write not from accumulator");
	property p_movc; memReq.code |-> !memReq.wr && memReq.addr == archState.dataPtr + {8'h00, archState.acc}; endproperty
	a_movc: assert property (p_movc) else $error("code read address wrong");
endmodule

// ==== tb/test_cpu_arith_logic_exec.sv ====
`timescale 1ns/10ps
module test_cpu_arith_logic_exec
	import exec_pkg::*;
;
	// ************************
	// Signals
	// ************************
	logic       sys_clk;
	logic       rst;
	instr_s     instr;
	logic       instrValid;
	logic       instrReady;
	logic       retired;
	logic       badOpcode;
	memreq_s    memReq;
	logic [7:0] memRdData;
	archstate_s archState;
	memreq_s    reqSeen;
	int         error_cnt;
	int         check_count;
	int         cycles;

	cpu_arith_logic_exec dut_u (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.instr      (instr),
		.instrValid (instrValid),
		.instrReady (instrReady),
		.retired    (retired),
		.badOpcode  (badOpcode),
		.memReq     (memReq),
		.memRdData  (memRdData),
		.archState  (archState)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ************************
	// Shared tasks
	// ************************
	task automatic end_of_test();
		$display("Checks made %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One instruction; length, busy window, flag pulse and idle request judged here
	task automatic exec(input logic [7:0] op, input int n, input logic [7:0] b1 = 8'h00,
			input logic [7:0] b2 = 8'h00, input logic [7:0] rd = 8'h00, input logic bad = 1'b0);
		int   k;
		logic busyOk;
		busyOk = 1'b1;
		@(negedge sys_clk);
		instr = '{opcode: op, byte1: b1, byte2: b2};
		instrValid = 1'b1;
		memRdData = rd;
		@(negedge sys_clk);
		instrValid = 1'b0;
		reqSeen = memReq;
		for (k = 1; k < 12; k++) begin
			@(posedge sys_clk);
			#1;
			if (retired === 1'b1) break;
			if (instrReady !== 1'b0) busyOk = 1'b0;
		end
		chk(48'(k), 48'(n), "cycle count");
		chk({46'h0, badOpcode, busyOk}, {46'h0, bad, 1'b1}, "bad flag or busy");
		chk(48'(memReq), 48'h0, "request left set");
	endtask

	task automatic ca(input logic [7:0] a, input logic [7:0] p);
		chk({32'h0, archState.acc, archState.psw}, {32'h0, a, p}, "acc and status");
	endtask

	// Write data is not judged on reads: its value there is unused
	task automatic rq(input logic [2:0] kind, input logic [15:0] a);
		chk({29'h0, reqSeen.rd, reqSeen.wr, reqSeen.code, reqSeen.addr}, {29'h0, kind, a}, "request");
	endtask

	// ************************
	// Scenarios
	// ************************
	task automatic t_reset();
		chk({46'h0, instrReady, retired}, 48'h2, "idle after reset");
		chk(48'(archState), 48'h0, "state after reset");
	endtask

	task automatic t_arith();
		exec(8'h74, 2, 8'h5a);
		exec(8'hf5, 2, 8'h3c);
		exec(8'h74, 2, 8'h3c);
		exec(8'hf8, 1);
		exec(8'h74, 2, 8'hc8);
		exec(8'h28, 1);
		ca(8'h04, 8'hc1);
		exec(8'h34, 2, 8'h10);
		ca(8'h15, 8'h01);
		exec(8'h94, 2, 8'h16);
		ca(8'hff, 8'hc0);
		exec(8'h98, 1);
		ca(8'hc2, 8'h01);
		exec(8'h25, 2, 8'h3c);
		ca(8'h1c, 8'h81);
		exec(8'h26, 2);
		ca(8'h76, 8'h41);
		exec(8'h38, 1);
		ca(8'hb2, 8'h44);
		exec(8'h96, 2);
		ca(8'h58, 8'h45);
	endtask

	task automatic t_incdec();
		exec(8'he4, 1);
		exec(8'h04, 1);
		ca(8'h01, 8'h45);
		exec(8'h14, 1);
		exec(8'h14, 1);
		ca(8'hff, 8'h44);
		exec(8'h08, 2);
		exec(8'he8, 1);
		ca(8'h3d, 8'h45);
		exec(8'h18, 2);
		exec(8'h05, 3, 8'h3c);
		exec(8'h16, 3);
		exec(8'h06, 3);
		exec(8'h15, 3, 8'h3c);
		exec(8'he5, 2, 8'h3c);
		ca(8'h5a, 8'h44);
		exec(8'h74, 2, 8'hff);
		exec(8'hf5, 2, 8'h82);
		exec(8'ha3, 1);
		chk(48'(archState.dataPtr), 48'h0100, "pointer increment");
	endtask

	task automatic t_muldiv();
		exec(8'h74, 2, 8'h30);
		exec(8'hf5, 2, 8'hf0);
		exec(8'h74, 2, 8'h0c);
		exec(8'ha4, 2);
		ca(8'h40, 8'h45);
		chk(48'(archState.b), 48'h02, "product high");
		exec(8'h84, 6);
		ca(8'h20, 8'h41);
		chk(48'(archState.b), 48'h00, "remainder");
		// Zero divisor leaves the accumulator alone and sets overflow; B is not checked
		exec(8'h84, 6);
		ca(8'h20, 8'h45);
		exec(8'h74, 2, 8'h38);
		exec(8'h24, 2, 8'h45);
		ca(8'h7d, 8'h00);
		exec(8'hd4, 3);
		ca(8'h83, 8'h01);
	endtask

	task automatic t_logic();
		logic [7:0] offs [6] = '{8'h08, 8'h05, 8'h06, 8'h04, 8'h02, 8'h03};
		int         cyc  [6] = '{1, 2, 2, 2, 3, 3};
		logic [7:0] base [3] = '{8'h50, 8'h40, 8'h60};
		logic [7:0] res  [3] = '{8'h44, 8'hde, 8'h9a};
		logic [7:0] uop  [7] = '{8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4};
		logic [7:0] ures [7] = '{8'h00, 8'h69, 8'h2d, 8'h2d, 8'h4b, 8'hcb, 8'h69};
		logic       ucy  [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		for (int o = 0; o < 3; o++) begin
			for (int f = 0; f < 6; f++) begin
				// Same operand 5c as register, pointer, memory and immediate
				exec(8'h74, 2, 8'h5c);
				exec(8'hf8, 1);
				exec(8'hf5, 2, 8'h5c);
				exec(8'h74, 2, 8'hc6);
				exec(base[o] + offs[f], cyc[f], 8'h5c, 8'hc6);
				if (f >= 4) exec(8'he5, 2, 8'h5c);
				chk(48'(archState.acc), 48'(res[o]), "logic result");
			end
		end
		for (int u = 0; u < 7; u++) begin
			exec(8'h74, 2, 8'h80);
			exec(8'hf5, 2, 8'hd0);
			exec(8'h74, 2, 8'h96);
			exec(uop[u], 1);
			chk({39'h0, archState.acc, archState.psw[7]}, {39'h0, ures[u], ucy[u]}, "unary");
		end
	endtask

	task automatic t_xfer();
		exec(8'he0, 3, 8'h00, 8'h00, 8'ha5);
		rq(3'b100, 16'h0100);
		ca(8'ha5, 8'h80);
		exec(8'hf0, 4);
		rq(3'b010, 16'h0100);
		chk(48'(reqSeen.wdata), 48'ha5, "write data");
		exec(8'he2, 4, 8'h00, 8'h00, 8'h3c);
		rq(3'b100, 16'h005c);
		exec(8'hf9, 1);
		exec(8'h74, 2, 8'h77);
		exec(8'hf3, 5);
		rq(3'b010, 16'h003c);
		chk(48'(reqSeen.wdata), 48'h77, "write data");
		exec(8'h74, 2, 8'h10);
		exec(8'h93, 5, 8'h00, 8'h00, 8'h9c);
		rq(3'b101, 16'h0110);
		chk(48'(archState.acc), 48'h9c, "lookup byte");
		exec(8'h85, 3, 8'h5c, 8'h61);
		exec(8'he5, 2, 8'h61);
		chk(48'(archState.acc), 48'h9a, "direct to direct");
		// Unsupported code is a one-cycle no-op
		exec(8'h02, 1, 8'h00, 8'h00, 8'h00, 1'b1);
		chk(48'(archState.acc), 48'h9a, "no-op kept state");
	endtask

	// ************************
	// Hang guard and sequence
	// ************************
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			$display("Error at %0t: run did not finish", $time);
			end_of_test();
		end
	end

	initial begin
		rst = 1'b1;
		instr = '0;
		instrValid = 1'b0;
		memRdData = 8'h00;
		reqSeen = '0;
		error_cnt = 0;
		check_count = 0;
		cycles = 0;
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		#1;
		t_reset();
		$display("Test reset done");
		t_arith();
		$display("Test arith done");
		t_incdec();
		$display("Test incdec done");
		t_muldiv();
		$display("Test muldiv done");
		t_logic();
		$display("Test logic done");
		t_xfer();
		$display("Test xfer done");
		end_of_test();
	end
endmodule
